// [verilog/hwrc_pkg.sv]
// Constants, field layout and carrier types of the watchdog and reset controller.
// Assumes a 100 MHz system clock and a crystal clock sampled as a synchronous input.

package hwrc_pkg;

  // ==========================================================
  // Timing
  localparam int unsigned CLK_HZ = 100_000_000;
  localparam int unsigned XTAL_HZ = 32768;
  localparam int unsigned WDT_TIMEOUT_MS = 1500;
  localparam int unsigned WDT_TIMEOUT_CYC = WDT_TIMEOUT_MS * XTAL_HZ / 1000;
  localparam int unsigned RESTART_XTAL_CYC = 4100;
  // Crystal declared dead after four nominal periods without an edge
  localparam int unsigned OSC_SLOW_NS = 122070;
  localparam int unsigned OSC_SLOW_CYC = OSC_SLOW_NS * (CLK_HZ / 1_000_000) / 1000;

  // ==========================================================
  // Widths
  localparam int unsigned CNT_W = 16;
  localparam int unsigned HOLD_W = 13;
  localparam int unsigned GAP_W = 24;
  localparam int unsigned ADDR_W = 16;
  localparam int unsigned CFG_W = 8;

  // ==========================================================
  // Register map
  localparam logic [ADDR_W-1:0] ADDR_REFRESH = 16'h0000;
  localparam logic [ADDR_W-1:0] ADDR_STATUS = 16'h0004;
  localparam logic [ADDR_W-1:0] IDX_CFG = 16'h2002;
  localparam logic [ADDR_W-1:0] ADDR_CFG = {IDX_CFG[ADDR_W-3:0], 2'b00};
  localparam int unsigned REFRESH_BIT = 0;
  localparam int unsigned OVF_BIT = 2;
  localparam int unsigned STAT_OSC_BAD_BIT = 16;
  localparam int unsigned STAT_INHIBIT_BIT = 17;
  localparam int unsigned STAT_HOLD_BIT = 18;
  localparam logic [CFG_W-1:0] CFG_RST = 8'h00;
  localparam logic [7:0] EMU_CMD_REFRESH = 8'h14;
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  // ==========================================================
  // Carrier types
  typedef struct packed {
    logic ext_reset_n_pin;
    logic emu_reset_n_pin;
    logic power_fault_sense;
    logic debug_disable;
    logic crystal_clock;
    logic wake_state;
  } hwrc_pins_t;

  typedef struct packed {
    logic valid;
    logic [7:0] cmd;
  } hwrc_emu_cmd_t;

  typedef enum logic [1:0] {ST_RUN, ST_PULSE, ST_HOLD} hwrc_state_t;

endpackage

// [verilog/hwrc_wdt_counter.sv]
// Watchdog count of crystal ticks with restart and one-cycle overflow pulse.
// Assumes i_tick is a one-cycle pulse per crystal rising edge.
`timescale 1ns/1ps

module hwrc_wdt_counter #(
  parameter int unsigned TIMEOUT = hwrc_pkg::WDT_TIMEOUT_CYC
) (
  input wire logic i_clock,
  input wire logic i_reset,
  input wire logic i_restart,
  input wire logic i_tick,
  output logic [hwrc_pkg::CNT_W-1:0] o_count,
  output logic o_overflow
);
  import hwrc_pkg::*;

  localparam logic [CNT_W-1:0] LAST = CNT_W'(TIMEOUT - 1);

  // ==========================================================
  // Count and overflow
  always_ff @(posedge i_clock) begin
    if (i_reset || i_restart) begin
      o_count <= '0;
      o_overflow <= 1'b0;
    end else if (i_tick && o_count == LAST) begin
      o_count <= '0;
      o_overflow <= 1'b1;
    end else if (i_tick) begin
      o_count <= o_count + 1'b1;
      o_overflow <= 1'b0;
    end else begin
      o_overflow <= 1'b0;
    end
  end

  chk_wrap_pulse: assert property (@(posedge i_clock) disable iff (i_reset)
    (i_tick && o_count == LAST && !i_restart) |=> (o_overflow && o_count == '0))
    else $error("watchdog did not overflow at the last count");

endmodule

// [verilog/hwrc_reset_ctrl.sv]
// Watchdog, crystal check and hardware reset sequencing with an AXI4-Lite register slave.
// Assumes all pins and the crystal clock arrive synchronous to i_clock.
//
// Our own choices: register access over AXI4-Lite and the register addresses.
`timescale 1ns/1ps

module hwrc_reset_ctrl #(
  parameter int unsigned WDT_TIMEOUT_CYC = hwrc_pkg::WDT_TIMEOUT_CYC,
  parameter int unsigned RESTART_XTAL_CYC = hwrc_pkg::RESTART_XTAL_CYC,
  parameter int unsigned OSC_SLOW_CYC = hwrc_pkg::OSC_SLOW_CYC
) (
  input wire logic i_clock,
  input wire logic i_reset,
  input wire hwrc_pkg::hwrc_pins_t i_pins,
  input wire hwrc_pkg::hwrc_emu_cmd_t i_emu_cmd,
  input wire logic [hwrc_pkg::ADDR_W-1:0] i_axi_awaddr,
  input wire logic i_axi_awvalid,
  output logic o_axi_awready,
  input wire logic [31:0] i_axi_wdata,
  input wire logic [3:0] i_axi_wstrb,
  input wire logic i_axi_wvalid,
  output logic o_axi_wready,
  output logic [1:0] o_axi_bresp,
  output logic o_axi_bvalid,
  input wire logic i_axi_bready,
  input wire logic [hwrc_pkg::ADDR_W-1:0] i_axi_araddr,
  input wire logic i_axi_arvalid,
  output logic o_axi_arready,
  output logic [31:0] o_axi_rdata,
  output logic [1:0] o_axi_rresp,
  output logic o_axi_rvalid,
  input wire logic i_axi_rready,
  output logic o_mpu_reset,
  output logic o_digital_hold,
  output logic o_config_clear,
  output logic o_overflow_flag,
  output logic [hwrc_pkg::CFG_W-1:0] o_config_bits
);
  import hwrc_pkg::*;

  localparam logic [HOLD_W-1:0] HOLD_LAST = HOLD_W'(RESTART_XTAL_CYC - 1);
  localparam logic [GAP_W-1:0] GAP_LAST = GAP_W'(OSC_SLOW_CYC - 1);

  // Known register offsets
  function automatic logic addr_ok(input logic [ADDR_W-1:0] a);
    addr_ok = (a == ADDR_REFRESH) || (a == ADDR_STATUS) || (a == ADDR_CFG);
  endfunction

  hwrc_state_t state_q, state_d;
  logic xtal_q;
  logic xtal_rise, xtal_fall;
  logic ext_rst, emu_rst, inhibit, pwr_fault, hard_src;
  logic [HOLD_W-1:0] hold_cnt_q;
  logic [GAP_W-1:0] gap_q;
  logic osc_bad_q, osc_stop, osc_resume;
  logic [CNT_W-1:0] wdt_count;
  logic wdt_ovf, wdt_restart, refresh_wr, emu_refresh;
  logic flag_q, flag_set, flag_clr;
  logic [CFG_W-1:0] cfg_q;
  logic aw_have_q, w_have_q;
  logic [ADDR_W-1:0] waddr_q;
  logic [31:0] wdata_q;
  logic [3:0] wstrb_q;
  logic do_write, cfg_wr, ar_hs;
  logic [31:0] rd_word;

  // ==========================================================
  // Reset sources
  assign ext_rst = !i_pins.ext_reset_n_pin;
  assign emu_rst = !i_pins.emu_reset_n_pin;
  assign inhibit = i_pins.debug_disable;
  assign pwr_fault = i_pins.power_fault_sense && !inhibit;
  assign hard_src = ext_rst || emu_rst || pwr_fault;

  // Crystal edge detection; tracks the pin through reset so no false edge follows it
  always_ff @(posedge i_clock) begin
    xtal_q <= i_pins.crystal_clock;
  end
  assign xtal_rise = i_pins.crystal_clock && !xtal_q;
  assign xtal_fall = !i_pins.crystal_clock && xtal_q;

  // ==========================================================
  // Crystal frequency check: cycles since the last rising edge
  always_ff @(posedge i_clock) begin
    if (i_reset || xtal_rise) begin
      gap_q <= '0;
    end else if (gap_q != GAP_LAST) begin
      gap_q <= gap_q + 1'b1;
    end
  end

  // Stop detection, one event per outage
  assign osc_stop = (gap_q == GAP_LAST - 1'b1) && !xtal_rise && !inhibit;
  assign osc_resume = osc_bad_q && xtal_rise && !inhibit;

  always_ff @(posedge i_clock) begin
    if (i_reset || xtal_rise) begin
      osc_bad_q <= 1'b0;
    end else if (osc_stop) begin
      osc_bad_q <= 1'b1;
    end
  end

  // ==========================================================
  // Watchdog count; held by the debug level, wake low, a reset source or a non-run state, no register can hold it
  assign emu_refresh = i_emu_cmd.valid && (i_emu_cmd.cmd == EMU_CMD_REFRESH);
  assign wdt_restart = refresh_wr || !i_pins.wake_state || emu_refresh
                    || inhibit || hard_src || (state_q != ST_RUN);

  hwrc_wdt_counter #(
    .TIMEOUT(WDT_TIMEOUT_CYC)
  ) u_counter (
    .i_clock(i_clock),
    .i_reset(i_reset),
    .i_restart(wdt_restart),
    .i_tick(xtal_rise),
    .o_count(wdt_count),
    .o_overflow(wdt_ovf)
  );

  // ==========================================================
  // Reset sequencer: half-period pulse, then a release delay
  always_comb begin
    state_d = state_q;
    if (hard_src) begin
      state_d = ST_HOLD;
    end else begin
      unique case (state_q)
        ST_RUN: begin
          if (wdt_ovf || osc_resume) begin
            state_d = ST_PULSE;
          end
        end
        ST_PULSE: begin
          if (xtal_fall) begin
            state_d = ST_HOLD;
          end
        end
        ST_HOLD: begin
          if (xtal_rise && hold_cnt_q == HOLD_LAST) begin
            state_d = ST_RUN;
          end
        end
      endcase
    end
  end

  always_ff @(posedge i_clock) begin
    if (i_reset) begin
      state_q <= ST_HOLD;
    end else begin
      state_q <= state_d;
    end
  end

  // Release delay in crystal cycles
  always_ff @(posedge i_clock) begin
    if (i_reset || hard_src || state_q != ST_HOLD) begin
      hold_cnt_q <= '0;
    end else if (xtal_rise) begin
      hold_cnt_q <= hold_cnt_q + 1'b1;
    end
  end

  // Registered reset outputs
  always_ff @(posedge i_clock) begin
    if (i_reset) begin
      o_mpu_reset <= 1'b1;
      o_digital_hold <= 1'b0;
      o_config_clear <= 1'b0;
    end else begin
      o_mpu_reset <= hard_src || (state_q != ST_RUN);
      o_digital_hold <= ext_rst || pwr_fault;
      o_config_clear <= ext_rst || pwr_fault;
    end
  end

  // ==========================================================
  // Overflow flag: set beats every clear
  assign flag_set = wdt_ovf || osc_stop;
  assign flag_clr = ext_rst || (cfg_wr && !wdata_q[OVF_BIT]);

  always_ff @(posedge i_clock) begin
    if (i_reset) begin
      flag_q <= 1'b0;
    end else if (flag_set) begin
      flag_q <= 1'b1;
    end else if (flag_clr) begin
      flag_q <= 1'b0;
    end
  end
  assign o_overflow_flag = flag_q;

  // Volatile configuration bits, the flag lane excluded
  always_ff @(posedge i_clock) begin
    if (i_reset || ext_rst || pwr_fault) begin
      cfg_q <= CFG_RST;
    end else if (cfg_wr) begin
      cfg_q <= wdata_q[CFG_W-1:0] & ~(CFG_W'(1) << OVF_BIT);
    end
  end
  assign o_config_bits = cfg_q | (CFG_W'(flag_q) << OVF_BIT);

  // ==========================================================
  // AXI4-Lite write: address and data latched in either order
  assign o_axi_awready = !aw_have_q && !o_axi_bvalid;
  assign o_axi_wready = !w_have_q && !o_axi_bvalid;
  assign do_write = aw_have_q && w_have_q && !o_axi_bvalid;
  assign cfg_wr = do_write && (waddr_q == ADDR_CFG) && wstrb_q[0];
  assign refresh_wr = do_write && (waddr_q == ADDR_REFRESH) && wstrb_q[0] && wdata_q[REFRESH_BIT];

  always_ff @(posedge i_clock) begin
    if (i_reset || do_write) begin
      aw_have_q <= 1'b0;
    end else if (i_axi_awvalid && o_axi_awready) begin
      aw_have_q <= 1'b1;
    end
  end

  always_ff @(posedge i_clock) begin
    if (i_reset) begin
      waddr_q <= '0;
    end else if (i_axi_awvalid && o_axi_awready) begin
      waddr_q <= i_axi_awaddr;
    end
  end

  always_ff @(posedge i_clock) begin
    if (i_reset || do_write) begin
      w_have_q <= 1'b0;
    end else if (i_axi_wvalid && o_axi_wready) begin
      w_have_q <= 1'b1;
    end
  end

  always_ff @(posedge i_clock) begin
    if (i_reset) begin
      wdata_q <= '0;
      wstrb_q <= '0;
    end else if (i_axi_wvalid && o_axi_wready) begin
      wdata_q <= i_axi_wdata;
      wstrb_q <= i_axi_wstrb;
    end
  end

  // Write response
  always_ff @(posedge i_clock) begin
    if (i_reset) begin
      o_axi_bvalid <= 1'b0;
      o_axi_bresp <= RESP_OKAY;
    end else if (do_write) begin
      o_axi_bvalid <= 1'b1;
      o_axi_bresp <= addr_ok(waddr_q) ? RESP_OKAY : RESP_SLVERR;
    end else if (i_axi_bready) begin
      o_axi_bvalid <= 1'b0;
    end
  end

  // ==========================================================
  // AXI4-Lite read; refresh bit always reads zero
  assign o_axi_arready = !o_axi_rvalid;
  assign ar_hs = i_axi_arvalid && o_axi_arready;

  always_comb begin
    rd_word = '0;
    if (i_axi_araddr == ADDR_STATUS) begin
      rd_word[CNT_W-1:0] = wdt_count;
      rd_word[STAT_OSC_BAD_BIT] = osc_bad_q;
      rd_word[STAT_INHIBIT_BIT] = inhibit;
      rd_word[STAT_HOLD_BIT] = (state_q != ST_RUN);
    end else if (i_axi_araddr == ADDR_CFG) begin
      rd_word[CFG_W-1:0] = o_config_bits;
    end
  end

  always_ff @(posedge i_clock) begin
    if (i_reset) begin
      o_axi_rvalid <= 1'b0;
      o_axi_rdata <= '0;
      o_axi_rresp <= RESP_OKAY;
    end else if (ar_hs) begin
      o_axi_rvalid <= 1'b1;
      o_axi_rdata <= rd_word;
      o_axi_rresp <= addr_ok(i_axi_araddr) ? RESP_OKAY : RESP_SLVERR;
    end else if (i_axi_rready) begin
      o_axi_rvalid <= 1'b0;
    end
  end

  // ==========================================================
  // Checks
  default clocking cb @(posedge i_clock); endclocking
  default disable iff (i_reset);

  chk_source_reset: assert property (hard_src |=> o_mpu_reset)
    else $error("reset source did not reach the MPU reset");
  chk_logic_hold: assert property ((ext_rst || pwr_fault) |=> (o_digital_hold && o_config_clear))
    else $error("digital logic not held during reset or supply fault");
  chk_config_clear: assert property ((ext_rst || pwr_fault) |=> (cfg_q == CFG_RST))
    else $error("configuration bits survived reset or supply fault");
  chk_pulse_entry: assert property ((wdt_ovf && !hard_src && state_q == ST_RUN)
    |=> (state_q == ST_PULSE) ##1 o_mpu_reset)
    else $error("overflow did not start the reset pulse");
  chk_pulse_end: assert property ((state_q == ST_PULSE && xtal_fall && !hard_src) |=> (state_q == ST_HOLD))
    else $error("reset pulse did not end at the crystal falling edge");
  chk_release_late: assert property ((state_q == ST_HOLD && hold_cnt_q != HOLD_LAST) |=> (state_q != ST_RUN))
    else $error("MPU released before the release delay");
  chk_release_time: assert property ((state_q == ST_HOLD && xtal_rise && hold_cnt_q == HOLD_LAST && !hard_src)
    |=> (state_q == ST_RUN) ##1 !o_mpu_reset)
    else $error("MPU not released after the release delay");
  chk_flag_set: assert property (flag_set |=> (flag_q && o_config_bits[OVF_BIT]))
    else $error("overflow flag not set");
  chk_flag_pin: assert property ((ext_rst && !flag_set) |=> !flag_q)
    else $error("reset pin did not clear the overflow flag");
  chk_osc_resume: assert property ((osc_resume && !hard_src && state_q == ST_RUN) |=> (state_q == ST_PULSE))
    else $error("crystal resume did not reset the system");
  chk_inhibit_hold: assert property (inhibit |-> (!pwr_fault ##1 (wdt_count == '0)))
    else $error("watchdog ran while inhibited");
  chk_refresh_restart: assert property (refresh_wr |=> (wdt_count == '0))
    else $error("refresh write did not restart the count");
  chk_wake_emu: assert property ((!i_pins.wake_state || emu_refresh) |=> (wdt_count == '0))
    else $error("wake or emulator refresh did not restart the count");
  chk_reset_restart: assert property ((state_q != ST_RUN) |=> (wdt_count == '0))
    else $error("count ran during a hardware reset");
  chk_refresh_zero: assert property ((ar_hs && i_axi_araddr == ADDR_REFRESH) |=> (o_axi_rdata == 32'h0000_0000))
    else $error("refresh bit did not read as zero");

  cov_overflow: cover property (wdt_ovf ##1 (state_q == ST_PULSE));
  cov_release: cover property ((state_q == ST_HOLD) ##1 (state_q == ST_RUN));
  cov_osc_resume: cover property (osc_resume);
  cov_refresh: cover property (refresh_wr);

endmodule

// [dv/hwrc_far_side.sv]
// Far side model: the crystal oscillator and the emulator command port.
// Assumes the bench system clock; outputs change by non-blocking assignment on rising edges.
`timescale 1ns/1ps

module hwrc_far_side #(
  parameter int HALF = 4
) (
  input wire logic i_clock,
  input wire logic i_run,
  output logic o_crystal_clock,
  output hwrc_pkg::hwrc_emu_cmd_t o_emu_cmd
);
  import hwrc_pkg::*;

  int ph_q = 0;

  initial begin
    o_crystal_clock = 1'b0;
    o_emu_cmd = '0;
  end

  // ==========================================================
  // Crystal: toggles every HALF clocks, stands still while stopped
  always @(posedge i_clock) begin
    if (i_run) begin
      if (ph_q == HALF - 1) begin
        ph_q <= 0;
        o_crystal_clock <= ~o_crystal_clock;
      end else begin
        ph_q <= ph_q + 1;
      end
    end
  end

  // ==========================================================
  // Emulator command: one-cycle pulse, code scrambled when idle
  task automatic emu_send(input logic [7:0] c);
    @(posedge i_clock);
    o_emu_cmd <= '{valid: 1'b1, cmd: c};
    @(posedge i_clock);
    o_emu_cmd <= '{valid: 1'b0, cmd: ~c};
  endtask
endmodule

// [dv/hwrc_reset_ctrl_tb.sv]
// Self-checking bench of the watchdog and reset controller over AXI4-Lite.
// Assumes shortened counts: timeout 8, restart 4, crystal period 8 clocks.
`timescale 1ns/1ps

`define CHECK(nm, e, g) begin total_checks++; if ((g) !== (e)) begin num_errors++; \
  $display("[FAIL] %s expected %h seen %h", nm, e, g); end end

module hwrc_reset_ctrl_tb;
  import hwrc_pkg::*;

  logic i_clock = 1'b0;
  logic i_reset = 1'b1;
  logic ext_n = 1'b1, emu_n = 1'b1, pf = 1'b0, dbg = 1'b0, wake = 1'b1, xrun = 1'b1, xtal;
  hwrc_pins_t pins;
  hwrc_emu_cmd_t emu;
  logic [15:0] awaddr = '0, araddr = '0;
  logic [31:0] wdata = '0, o_axi_rdata;
  logic [3:0] wstrb = '0;
  logic awvalid = 0, wvalid = 0, bready = 0, arvalid = 0, rready = 0;
  logic o_axi_awready, o_axi_wready, o_axi_bvalid, o_axi_arready, o_axi_rvalid;
  logic [1:0] o_axi_bresp, o_axi_rresp, r;
  logic [31:0] d;
  logic o_mpu_reset, o_digital_hold, o_config_clear, o_overflow_flag;
  logic [CFG_W-1:0] o_config_bits;
  int num_errors = 0;
  int total_checks = 0;
  int n;

  assign pins = {ext_n, emu_n, pf, dbg, xtal, wake};

  // ==========================================================
  // Clock, far side and design
  initial forever #5 i_clock = ~i_clock;

  hwrc_far_side far (.i_clock(i_clock), .i_run(xrun), .o_crystal_clock(xtal), .o_emu_cmd(emu));

  hwrc_reset_ctrl #(.WDT_TIMEOUT_CYC(8), .RESTART_XTAL_CYC(4), .OSC_SLOW_CYC(64)) uut (
    .i_clock(i_clock), .i_reset(i_reset), .i_pins(pins), .i_emu_cmd(emu),
    .i_axi_awaddr(awaddr), .i_axi_awvalid(awvalid), .o_axi_awready(o_axi_awready),
    .i_axi_wdata(wdata), .i_axi_wstrb(wstrb), .i_axi_wvalid(wvalid), .o_axi_wready(o_axi_wready),
    .o_axi_bresp(o_axi_bresp), .o_axi_bvalid(o_axi_bvalid), .i_axi_bready(bready),
    .i_axi_araddr(araddr), .i_axi_arvalid(arvalid), .o_axi_arready(o_axi_arready),
    .o_axi_rdata(o_axi_rdata), .o_axi_rresp(o_axi_rresp), .o_axi_rvalid(o_axi_rvalid),
    .i_axi_rready(rready), .o_mpu_reset(o_mpu_reset), .o_digital_hold(o_digital_hold),
    .o_config_clear(o_config_clear), .o_overflow_flag(o_overflow_flag), .o_config_bits(o_config_bits));

  // ==========================================================
  // Verdict and hang guard
  task automatic close_out();
    if (num_errors == 0 && total_checks > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask

  initial begin
    repeat (20000) @(posedge i_clock);
    num_errors++;
    close_out();
  end

  // ==========================================================
  // Bus master: handshakes sampled mid-cycle, released after the edge
  task automatic axi_write(input logic [15:0] a, input logic [31:0] v, output logic [1:0] rs);
    logic aw_t, w_t, b_t;
    b_t = 1'b0;
    @(posedge i_clock);
    awaddr <= a; awvalid <= 1'b1; wdata <= v; wstrb <= 4'hF; wvalid <= 1'b1; bready <= 1'b1;
    while (!b_t) begin
      @(negedge i_clock);
      aw_t = awvalid && o_axi_awready;
      w_t = wvalid && o_axi_wready;
      b_t = o_axi_bvalid;
      rs = o_axi_bresp;
      @(posedge i_clock);
      if (aw_t) awvalid <= 1'b0;
      if (w_t) wvalid <= 1'b0;
    end
    bready <= 1'b0;
  endtask

  task automatic axi_read(input logic [15:0] a, output logic [31:0] v, output logic [1:0] rs);
    logic hs;
    hs = 1'b0;
    @(posedge i_clock);
    araddr <= a; arvalid <= 1'b1; rready <= 1'b1;
    while (!hs) begin
      @(negedge i_clock);
      hs = o_axi_arready;
      @(posedge i_clock);
    end
    arvalid <= 1'b0;
    hs = 1'b0;
    while (!hs) begin
      @(negedge i_clock);
      hs = o_axi_rvalid;
      v = o_axi_rdata;
      rs = o_axi_rresp;
      @(posedge i_clock);
    end
    rready <= 1'b0;
  endtask

  task automatic wr(input logic [15:0] a, input logic [31:0] v);
    logic [1:0] rs;
    axi_write(a, v, rs);
    `CHECK("write response", RESP_OKAY, rs)
  endtask

  task automatic rd_chk(input string nm, input logic [15:0] a, input logic [31:0] m, input logic [31:0] e);
    logic [31:0] v;
    logic [1:0] rs;
    axi_read(a, v, rs);
    `CHECK(nm, e, v & m)
  endtask

  // Waits for the MPU reset level, bounded, counting cycles
  task automatic wait_rst(input logic lvl, input int lim, output int cnt);
    cnt = 0;
    #1;
    while (o_mpu_reset !== lvl && cnt < lim) begin
      @(posedge i_clock);
      #1;
      cnt++;
    end
    `CHECK("mpu reset level", lvl, o_mpu_reset)
  endtask

  // ==========================================================
  // Test sequence
  initial begin
    repeat (12) @(posedge i_clock);
    i_reset <= 1'b0;
    wait_rst(1'b0, 300, n);
    `CHECK("restart delay", 1'b1, n >= 24)
    rd_chk("config after reset", ADDR_CFG, 32'hFF, 32'h0);
    // Refresh writes keep the MPU running
    for (int i = 0; i < 8; i++) begin
      wr(ADDR_REFRESH, 32'h1);
      repeat (30) @(posedge i_clock);
      `CHECK("refreshed", 1'b0, o_mpu_reset)
    end
    rd_chk("refresh readback", ADDR_REFRESH, 32'h1, 32'h0);
    // Wake low and emulator command restart the count
    wake <= 1'b0;
    repeat (200) @(posedge i_clock);
    `CHECK("wake low", 1'b0, o_mpu_reset)
    wake <= 1'b1;
    for (int i = 0; i < 6; i++) begin
      far.emu_send(EMU_CMD_REFRESH);
      repeat (40) @(posedge i_clock);
      `CHECK("emulator refresh", 1'b0, o_mpu_reset)
    end
    // Debug level inhibits watchdog and fault detection
    dbg <= 1'b1;
    pf <= 1'b1;
    repeat (200) @(posedge i_clock);
    `CHECK("debug inhibit", 1'b0, o_mpu_reset)
    `CHECK("debug no hold", 1'b0, o_digital_hold)
    rd_chk("inhibit status", ADDR_STATUS, (32'h1 << STAT_INHIBIT_BIT) | 32'h0000_FFFF, 32'h1 << STAT_INHIBIT_BIT);
    pf <= 1'b0;
    dbg <= 1'b0;
    // Overflow despite the config and refresh registers written
    wr(ADDR_CFG, 32'hFF);
    wr(ADDR_REFRESH, 32'h0);
    wait_rst(1'b1, 200, n);
    `CHECK("overflow flag", 1'b1, o_overflow_flag)
    wait_rst(1'b0, 300, n);
    `CHECK("overflow restart delay", 1'b1, n >= 24)
    wake <= 1'b0;
    rd_chk("flag field", ADDR_CFG, 32'h1 << OVF_BIT, 32'h1 << OVF_BIT);
    // Reset pin stops logic, clears config and flag
    ext_n <= 1'b0;
    repeat (3) @(posedge i_clock);
    `CHECK("pin hold", 1'b1, o_digital_hold)
    `CHECK("pin clear", 1'b1, o_config_clear)
    `CHECK("pin mpu reset", 1'b1, o_mpu_reset)
    `CHECK("pin flag", 1'b0, o_overflow_flag)
    `CHECK("pin config", 8'h00, o_config_bits)
    ext_n <= 1'b1;
    wait_rst(1'b0, 300, n);
    // Supply fault
    wr(ADDR_CFG, 32'h3);
    pf <= 1'b1;
    repeat (3) @(posedge i_clock);
    `CHECK("fault hold", 1'b1, o_digital_hold)
    `CHECK("fault config", 8'h00, o_config_bits)
    `CHECK("fault clear", 1'b1, o_config_clear)
    pf <= 1'b0;
    wait_rst(1'b0, 300, n);
    // Emulator reset pin
    emu_n <= 1'b0;
    repeat (3) @(posedge i_clock);
    `CHECK("emulator pin reset", 1'b1, o_mpu_reset)
    emu_n <= 1'b1;
    wait_rst(1'b0, 300, n);
    // Crystal stops, then resumes
    xrun <= 1'b0;
    repeat (100) @(posedge i_clock);
    `CHECK("crystal fail flag", 1'b1, o_overflow_flag)
    rd_chk("crystal status", ADDR_STATUS, 32'h1 << STAT_OSC_BAD_BIT, 32'h1 << STAT_OSC_BAD_BIT);
    xrun <= 1'b1;
    wait_rst(1'b1, 40, n);
    wait_rst(1'b0, 300, n);
    wr(ADDR_CFG, 32'h0);
    `CHECK("firmware clear", 1'b0, o_overflow_flag)
    // Unmapped address
    axi_write(16'h0100, 32'h1, r);
    `CHECK("unmapped write", RESP_SLVERR, r)
    axi_read(16'h0100, d, r);
    `CHECK("unmapped read", RESP_SLVERR, r)
    `CHECK("unmapped data", 32'h0, d)
    close_out();
  end
endmodule
